// ===== rtl/scr_cfg.svh
// Constants for the calibration readout and bank read block
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// APB register byte offsets
`define SCR_OFS_CFG      12'h000
`define SCR_OFS_STATUS   12'h004
`define SCR_OFS_VIOL     12'h008
`define SCR_OFS_ROW      12'h00c

// Configuration register fields and reset value
`define SCR_CFG_CL       0
`define SCR_CFG_AL       4
`define SCR_CFG_CWL      8
`define SCR_CFG_REP      12
`define SCR_CFG_BSEL     13
`define SCR_CFG_RESET    16'h0506

// Violation flag positions
`define SCR_V_IDLE       0
`define SCR_V_EARLY_ACT  1
`define SCR_V_PAT_WRITE  2
`define SCR_V_PAT_CMD    3

// Mode register selects and fields
`define SCR_MR_ZERO      3'h0
`define SCR_MR_THREE     3'h3
`define SCR_A_PAT_EN     2
`define SCR_A_NIBBLE     2
`define SCR_A_AUTOCLOSE  10
`define SCR_A_CHOP       12
`define SCR_BL_FIXED8    2'h0
`define SCR_BL_OTF       2'h1
`define SCR_BL_CHOP      2'h2
`define SCR_LOC_PATTERN  2'h0
`define SCR_CAL_PATTERN  8'haa

// Timing
`define SCR_CLK_NS       8
`define SCR_TRP_NS       15
`define SCR_TRP_CYC      ((`SCR_TRP_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_PIPE_DEPTH   32

`endif

// ===== rtl/scr_pkg.sv
// Types shared by the calibration readout block
`default_nettype none
`include "scr_cfg.svh"
package scr_pkg;

    typedef enum logic [2:0] {
        SCR_CMD_MODE = 3'h0,
        SCR_CMD_REF  = 3'h1,
        SCR_CMD_PRE  = 3'h2,
        SCR_CMD_ACT  = 3'h3,
        SCR_CMD_WR   = 3'h4,
        SCR_CMD_RD   = 3'h5,
        SCR_CMD_ZQ   = 3'h6,
        SCR_CMD_NOP  = 3'h7
    } scr_cmd_t;

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic       pat;
        logic       ac;
        logic [2:0] bank;
        logic [2:0] first;
        logic [2:0] last;
    } scr_slot_t;

    typedef struct packed {
        logic [36:0] s1;
        logic [36:0] s2;
        logic        ck_d;
        logic        rise;
        logic        fall;
        logic        valid;
        logic [2:0]  cmd;
        logic [2:0]  ba;
        logic [12:0] addr;
        logic [15:0] dq;
    } scr_front_t;

    typedef struct packed {
        logic [1:0]                              mr0_bl;
        logic                                    pat_en;
        logic [1:0]                              loc;
        logic [15:0]                             cfg;
        logic [3:0]                              viol;
        logic [7:0]                              bank_open;
        logic [7:0][11:0]                        row;
        logic [7:0][7:0]                         pre_cnt;
        logic [`SCR_PIPE_DEPTH-1:0][12:0]        pipe;
        scr_slot_t                               cur;
        logic [2:0]                              beat;
        logic [63:0][15:0]                       mem;
        logic [15:0]                             dq_out;
        logic                                    dq_oe;
        logic                                    dqs_out;
        logic                                    dqs_oe;
        logic [31:0]                             prdata;
        logic                                    pready;
        logic                                    pslverr;
    } scr_core_t;

endpackage
`default_nettype wire

// ===== rtl/scr_link_front.sv
// Link front end: synchronises command pins and finds memory clock edges
`default_nettype none
module scr_link_front (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              mem_ck,
    input  wire logic              mem_cs_n,
    input  wire logic              mem_ras_n,
    input  wire logic              mem_cas_n,
    input  wire logic              mem_we_n,
    input  wire logic [2:0]        mem_ba,
    input  wire logic [12:0]       mem_addr,
    input  wire logic [15:0]       mem_dq_in,
    output logic                   ck_rise,
    output logic                   ck_fall,
    output logic                   cmd_valid,
    output scr_pkg::scr_cmd_t      cmd_code,
    output logic [2:0]             cmd_ba,
    output logic [12:0]            cmd_addr,
    output logic [15:0]            dq_data
);
    import scr_pkg::*;

    scr_front_t q;
    scr_front_t n;

    // ************************************************************
    // Synchroniser and edge finder
    // ************************************************************
    // Only the second stage feeds the edge finder, so a metastable
    // first stage never reaches the command decode.
    always_comb begin
        n       = q;
        n.s1    = {mem_ck, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr, mem_dq_in};
        n.s2    = q.s1;
        n.ck_d  = q.s2[36];
        n.rise  = q.s2[36] && !q.ck_d;
        n.fall  = !q.s2[36] && q.ck_d;
        n.valid = q.s2[36] && !q.ck_d && !q.s2[35];
        n.cmd   = q.s2[34:32];
        n.ba    = q.s2[31:29];
        n.addr  = q.s2[28:16];
        n.dq    = q.s2[15:0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign ck_rise   = q.rise;
    assign ck_fall   = q.fall;
    assign cmd_valid = q.valid;
    assign cmd_code  = scr_cmd_t'(q.cmd);
    assign cmd_ba    = q.ba;
    assign cmd_addr  = q.addr;
    assign dq_data   = q.dq;

endmodule
`default_nettype wire

// ===== rtl/scr_calib_readout.sv
// Memory device core: pattern readout, bank state and read/write bursts
//
// Design decisions made here: the APB register port and the register addresses.
`default_nettype none
`include "scr_cfg.svh"
// Notes on behaviour
// - Pattern enable at location zero redirects reads
// - Eight-beat pattern read gives 0,1,0,1,0,1,0,1
// - Chopped pattern read picks nibble by column bit
// - Beat zero is LSB, beat seven MSB
// - Burst starts after additive plus column latency
// - Pattern disabled means array reads and writes
// - Activation opens given row in given bank
// - Precharge closes banks; reopen after precharge time
// - Other banks usable during concurrent autoclose
// - Precharged bank is idle until activated
// - Precharge to idle bank restarts its timer
// - In field 01 chop bit zero four beats, one eight
// - Chop bit never used as column address
// - Eight beats for field 00, or 01 with chop high
// - Autoclose read acts as plain read in pattern mode
// - Line zero of each lane carries pattern bit
module scr_calib_readout (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              mem_ck,
    input  wire logic              mem_cs_n,
    input  wire logic              mem_ras_n,
    input  wire logic              mem_cas_n,
    input  wire logic              mem_we_n,
    input  wire logic [2:0]        mem_ba,
    input  wire logic [12:0]       mem_addr,
    input  wire logic [15:0]       mem_dq_in,
    output logic [15:0]            mem_dq_out,
    output logic                   mem_dq_oe,
    output logic                   mem_dqs_out,
    output logic                   mem_dqs_oe
);
    import scr_pkg::*;

    scr_core_t  q;
    scr_core_t  n;
    logic       f_rise;
    logic       f_fall;
    logic       f_valid;
    scr_cmd_t   f_cmd;
    logic [2:0] f_ba;
    logic [12:0] f_addr;
    logic [15:0] f_dq;
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic       done;
    logic       bc4;
    logic [4:0] lat;
    logic [4:0] idx;
    scr_slot_t  slot;
    logic [4:0] rd_idx_h;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic pat_bit(input logic [1:0] loc, input logic [2:0] beat);
        logic [7:0] p;
        p = `SCR_CAL_PATTERN;
        // Reserved locations carry no defined data, so they read as zero
        pat_bit = (loc == `SCR_LOC_PATTERN) && p[beat];
    endfunction

    function automatic logic [4:0] lat_index(input logic [3:0] a, input logic [3:0] c);
        logic [4:0] sum;
        sum = {1'b0, a} + {1'b0, c};
        lat_index = (sum == 5'h00) ? 5'h00 : 5'(sum - 5'h01);
    endfunction

    scr_link_front u_front (
        .clk       (clk),
        .rst_n     (rst_n),
        .mem_ck    (mem_ck),
        .mem_cs_n  (mem_cs_n),
        .mem_ras_n (mem_ras_n),
        .mem_cas_n (mem_cas_n),
        .mem_we_n  (mem_we_n),
        .mem_ba    (mem_ba),
        .mem_addr  (mem_addr),
        .mem_dq_in (mem_dq_in),
        .ck_rise   (f_rise),
        .ck_fall   (f_fall),
        .cmd_valid (f_valid),
        .cmd_code  (f_cmd),
        .cmd_ba    (f_ba),
        .cmd_addr  (f_addr),
        .dq_data   (f_dq)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n     = q;
        set_v = 4'h0;
        clr_v = 4'h0;
        done  = 1'b0;
        bc4   = 1'b0;
        lat   = 5'h00;
        idx   = 5'h00;
        slot  = '0;

        // APB slave, one wait state; unmapped offsets answer with an error
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            n.pready = 1'b1;
            unique case (paddr)
                `SCR_OFS_CFG: begin
                    n.prdata = {16'h0000, q.cfg};
                    if (pwrite) begin
                        n.cfg = pwdata[15:0];
                    end
                end
                `SCR_OFS_STATUS: begin
                    n.prdata = {18'h00000, q.cur.valid, q.bank_open, q.mr0_bl, q.loc, q.pat_en};
                end
                `SCR_OFS_VIOL: begin
                    n.prdata = {28'h0000000, q.viol};
                    if (pwrite) begin
                        clr_v = pwdata[3:0];
                    end
                end
                `SCR_OFS_ROW: begin
                    n.prdata = {20'h00000, q.row[q.cfg[`SCR_CFG_BSEL +: 3]]};
                end
                default: begin
                    n.prdata  = 32'h00000000;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        // Precharge timers run on the core clock
        for (int b = 0; b < 8; b++) begin
            if (q.pre_cnt[b] != 8'h00) begin
                n.pre_cnt[b] = q.pre_cnt[b] - 8'h01;
            end
        end

        // ********************************************************
        // Burst engine, one beat per link clock edge
        // ********************************************************
        if (f_rise || f_fall) begin
            done = q.cur.valid && (q.beat == q.cur.last);
            // Autoclose runs at burst end; other banks stay usable meanwhile
            if (done && q.cur.ac && !q.cur.pat) begin
                n.bank_open[q.cur.bank] = 1'b0;
                n.pre_cnt[q.cur.bank]   = 8'(`SCR_TRP_CYC);
            end
            if (f_rise && q.pipe[0][12]) begin
                n.cur  = scr_slot_t'(q.pipe[0]);
                n.beat = n.cur.first;
            end else if (done) begin
                n.cur.valid = 1'b0;
            end else if (q.cur.valid) begin
                n.beat = q.beat + 3'h1;
            end
            // Write data is taken at the edge that opens each beat
            if (n.cur.valid && n.cur.wr) begin
                n.mem[{n.cur.bank, n.beat}] = f_dq;
            end
            n.dq_oe   = n.cur.valid && !n.cur.wr;
            n.dqs_oe  = n.cur.valid && !n.cur.wr;
            n.dqs_out = f_rise && n.dq_oe;
            if (!n.dq_oe) begin
                n.dq_out = 16'h0000;
            end else if (n.cur.pat) begin
                if (q.cfg[`SCR_CFG_REP]) begin
                    n.dq_out = {16{pat_bit(q.loc, n.beat)}};
                end else begin
                    n.dq_out = {7'h00, pat_bit(q.loc, n.beat), 7'h00, pat_bit(q.loc, n.beat)};
                end
            end else begin
                n.dq_out = q.mem[{n.cur.bank, n.beat}];
            end
        end

        // Latency line advances once per link clock
        if (f_rise) begin
            for (int i = 0; i < `SCR_PIPE_DEPTH - 1; i++) begin
                n.pipe[i] = q.pipe[i + 1];
            end
            n.pipe[`SCR_PIPE_DEPTH - 1] = 13'h0000;
        end

        // ********************************************************
        // Command decode
        // ********************************************************
        if (f_valid) begin
            bc4 = (q.mr0_bl == `SCR_BL_CHOP) ||
                  ((q.mr0_bl == `SCR_BL_OTF) && !f_addr[`SCR_A_CHOP]);
            unique case (f_cmd)
                SCR_CMD_MODE: begin
                    if (f_ba == `SCR_MR_ZERO) begin
                        n.mr0_bl = f_addr[1:0];
                    end
                    if (f_ba == `SCR_MR_THREE) begin
                        n.pat_en = f_addr[`SCR_A_PAT_EN];
                        n.loc    = f_addr[1:0];
                    end
                end
                SCR_CMD_ACT: begin
                    if (q.pat_en) begin
                        set_v[`SCR_V_PAT_CMD] = 1'b1;
                    end else begin
                        if (q.pre_cnt[f_ba] != 8'h00) begin
                            set_v[`SCR_V_EARLY_ACT] = 1'b1;
                        end
                        n.bank_open[f_ba] = 1'b1;
                        n.row[f_ba]       = f_addr[11:0];
                    end
                end
                SCR_CMD_PRE: begin
                    if (q.pat_en) begin
                        set_v[`SCR_V_PAT_CMD] = 1'b1;
                    end else if (f_addr[`SCR_A_AUTOCLOSE]) begin
                        n.bank_open = 8'h00;
                        for (int b = 0; b < 8; b++) begin
                            n.pre_cnt[b] = 8'(`SCR_TRP_CYC);
                        end
                    end else begin
                        // A repeated precharge simply restarts the timer
                        n.bank_open[f_ba] = 1'b0;
                        n.pre_cnt[f_ba]   = 8'(`SCR_TRP_CYC);
                    end
                end
                SCR_CMD_RD, SCR_CMD_WR: begin
                    if ((f_cmd == SCR_CMD_WR) && q.pat_en) begin
                        set_v[`SCR_V_PAT_WRITE] = 1'b1;
                    end else if (!q.pat_en && !q.bank_open[f_ba]) begin
                        set_v[`SCR_V_IDLE] = 1'b1;
                    end else begin
                        if (f_cmd == SCR_CMD_WR) begin
                            lat = lat_index(q.cfg[`SCR_CFG_AL +: 4], q.cfg[`SCR_CFG_CWL +: 4]);
                        end else begin
                            lat = lat_index(q.cfg[`SCR_CFG_AL +: 4], q.cfg[`SCR_CFG_CL +: 4]);
                        end
                        idx        = lat;
                        slot.valid = 1'b1;
                        slot.wr    = (f_cmd == SCR_CMD_WR);
                        slot.pat   = q.pat_en;
                        slot.ac    = f_addr[`SCR_A_AUTOCLOSE];
                        slot.bank  = f_ba;
                        // Chop bit selects length only, never a column
                        slot.first = bc4 ? {f_addr[`SCR_A_NIBBLE], 2'b00} : 3'h0;
                        slot.last  = bc4 ? 3'(slot.first + 3'h3) : 3'h7;
                        n.pipe[idx] = slot;
                    end
                end
                SCR_CMD_NOP: begin
                end
                default: begin
                    if (q.pat_en) begin
                        set_v[`SCR_V_PAT_CMD] = 1'b1;
                    end
                end
            endcase
        end

        // A new violation wins over a clear in the same cycle
        n.viol = (q.viol & ~clr_v) | set_v;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q     <= '0;
            q.cfg <= `SCR_CFG_RESET;
        end else begin
            q <= n;
        end
    end

    assign prdata      = q.prdata;
    assign pready      = q.pready;
    assign pslverr     = q.pslverr;
    assign mem_dq_out  = q.dq_out;
    assign mem_dq_oe   = q.dq_oe;
    assign mem_dqs_out = q.dqs_out;
    assign mem_dqs_oe  = q.dqs_oe;

    // ************************************************************
    // Checks
    // ************************************************************
    assign rd_idx_h = lat_index(q.cfg[`SCR_CFG_AL +: 4], q.cfg[`SCR_CFG_CL +: 4]);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_pattern_bits: assert property (
        (q.dq_oe && q.cur.pat && q.loc == `SCR_LOC_PATTERN) |-> (q.dq_out[0] == !q.dqs_out))
        else $error("pattern bit does not follow beat parity");

    chk_lane_copy: assert property (
        (q.dq_oe && q.cur.pat) |->
        (q.dq_out[8] == q.dq_out[0]) && ((q.dq_out[7:1] == 7'h00) || (&q.dq_out[7:1] == q.dq_out[0])))
        else $error("lane lines disagree with pattern bit");

    chk_upper_nibble: assert property (
        (f_rise && q.pipe[0][12] && q.pipe[0][10] && q.pipe[0][5:3] == 3'h4 &&
         q.loc == `SCR_LOC_PATTERN) |=> (q.beat == 3'h4) && (q.dq_out[0] == 1'b0) && q.dqs_out)
        else $error("upper nibble pattern read starts wrong");

    chk_mode_capture: assert property (
        (f_valid && f_cmd == SCR_CMD_MODE && f_ba == `SCR_MR_THREE) |=>
        (q.pat_en == $past(f_addr[`SCR_A_PAT_EN])) && (q.loc == $past(f_addr[1:0])))
        else $error("mode register three not captured");

    chk_idle_flag: assert property (
        (f_valid && (f_cmd == SCR_CMD_RD) && !q.pat_en && !q.bank_open[f_ba]) |=>
        q.viol[`SCR_V_IDLE])
        else $error("read to idle bank not flagged");

    chk_act_opens: assert property (
        (f_valid && f_cmd == SCR_CMD_ACT && !q.pat_en) |=>
        q.bank_open[$past(f_ba)] && (q.row[$past(f_ba)] == $past(f_addr[11:0])))
        else $error("activation did not open row");

    chk_pre_closes: assert property (
        (f_valid && f_cmd == SCR_CMD_PRE && !q.pat_en && !f_addr[`SCR_A_AUTOCLOSE]) |=>
        !q.bank_open[$past(f_ba)] && (q.pre_cnt[$past(f_ba)] == 8'(`SCR_TRP_CYC)))
        else $error("precharge did not close bank or restart timer");

    chk_early_act: assert property (
        (f_valid && f_cmd == SCR_CMD_ACT && !q.pat_en && q.pre_cnt[f_ba] != 8'h00) |=>
        q.viol[`SCR_V_EARLY_ACT])
        else $error("early activation not flagged");

    chk_write_blocked: assert property (
        (f_valid && f_cmd == SCR_CMD_WR && q.pat_en) |=> q.viol[`SCR_V_PAT_WRITE] &&
        !q.pipe[lat_index(q.cfg[`SCR_CFG_AL +: 4], q.cfg[`SCR_CFG_CWL +: 4])][11])
        else $error("write in pattern mode not refused");

    chk_read_latency: assert property (
        (f_valid && f_cmd == SCR_CMD_RD && q.pat_en) |=> q.pipe[rd_idx_h][12])
        else $error("pattern read not scheduled at read latency");

    chk_pat_autoclose: assert property (
        ((f_rise || f_fall) && q.cur.valid && q.cur.pat && q.beat == q.cur.last && !f_valid) |=>
        $stable(q.bank_open))
        else $error("autoclose acted in pattern mode");

endmodule
`default_nettype wire

// ===== sim/scr_ctrl_model.sv
// Memory controller model: free link clock, command pins and write data
`default_nettype none
module scr_ctrl_model (
    output logic        mem_ck,
    output logic        mem_cs_n,
    output logic        mem_ras_n,
    output logic        mem_cas_n,
    output logic        mem_we_n,
    output logic [2:0]  mem_ba,
    output logic [12:0] mem_addr,
    output logic [15:0] mem_dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import scr_pkg::*;
    initial begin
        mem_ck = 1'b0;
        mem_cs_n = 1'b1;
        {mem_ras_n, mem_cas_n, mem_we_n} = 3'h7;
        mem_ba = 3'h0;
        mem_addr = 13'h0000;
        mem_dq_in = 16'h5a5a;
    end
    // A memory clock runs free, so it is not stopped between commands
    always #62.5 mem_ck <= ~mem_ck;
    // Launch on the falling edge so the device sees stable pins at the rise;
    // released bank and address lines show the inverse so stale values cannot pass for live ones
    task automatic cmd(input scr_cmd_t c, input logic [2:0] ba, input logic [12:0] a,
                       input int gap);
        @(negedge mem_ck);
        mem_cs_n <= 1'b0;
        {mem_ras_n, mem_cas_n, mem_we_n} <= c;
        mem_ba <= ba;
        mem_addr <= a;
        @(negedge mem_ck);
        mem_cs_n <= 1'b1;
        {mem_ras_n, mem_cas_n, mem_we_n} <= SCR_CMD_NOP;
        mem_ba <= ~ba;
        mem_addr <= ~a;
        repeat (gap) @(negedge mem_ck);
    endtask
    // Write data is held across the whole beat window, inverted afterwards
    task automatic wr(input logic [2:0] ba, input logic [12:0] a, input logic [15:0] w);
        mem_dq_in <= w;
        cmd(SCR_CMD_WR, ba, a, 10);
        mem_dq_in <= ~w;
    endtask
endmodule
`default_nettype wire

// ===== sim/test_scr_calib_readout.sv
// Self-checking bench for the calibration readout block
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module test_scr_calib_readout;
    timeunit 1ns;
    timeprecision 100ps;
    import scr_pkg::*;
    localparam logic [7:0] ALT = 8'haa;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        mem_ck, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
    logic [2:0]  mem_ba;
    logic [12:0] mem_addr;
    logic [15:0] mem_dq_in, mem_dq_out;
    logic        mem_dq_oe, mem_dqs_out, mem_dqs_oe, oe_p, dqs_p;
    logic [15:0] beats[$];
    int          fail_count = 0, check_count = 0, ck_n = 0, first_ck = 0, oe_bad = 0;
    scr_calib_readout dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_ck(mem_ck), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
        .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
        .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .mem_dqs_out(mem_dqs_out), .mem_dqs_oe(mem_dqs_oe));
    scr_ctrl_model ctrl_u (.mem_ck(mem_ck), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
        .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
        .mem_dq_in(mem_dq_in));
    always #4 clk = ~clk;
    always @(posedge mem_ck) ck_n++;
    // A beat is a new strobe level while the data lines are driven
    always @(posedge clk) begin
        // Strobe enable must track the data enable on every cycle
        if (mem_dq_oe !== mem_dqs_oe) oe_bad++;
        if (mem_dq_oe === 1'b1 && (oe_p !== 1'b1 || mem_dqs_out !== dqs_p)) begin
            if (beats.size() == 0) first_ck = ck_n;
            beats.push_back(mem_dq_out);
        end
        oe_p <= mem_dq_oe;
        dqs_p <= mem_dqs_out;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Beat b is expected as one when bit b of bits is set, zero otherwise
    task automatic rd_chk(input logic [2:0] ba, input logic [12:0] a, input int n,
                          input int lat, input logic [7:0] bits, input logic [15:0] one);
        int k;
        beats.delete();
        ctrl_u.cmd(SCR_CMD_RD, ba, a, 0);
        k = ck_n;
        repeat (lat + 6) @(posedge mem_ck);
        repeat (8) @(posedge clk);
        `CHK(beats.size(), n)
        `CHK(oe_bad, 0)
        for (int b = 0; b < n && b < beats.size(); b++) `CHK(beats[b], bits[b] ? one : 16'h0)
        if (n > 0) `CHK(first_ck - k, lat)
    endtask
    task automatic end_sim;
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #300us;
        fail_count++;
        end_sim();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0506)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        ctrl_u.cmd(SCR_CMD_MODE, 3'h0, 13'h0001, 12);
        ctrl_u.cmd(SCR_CMD_ACT, 3'h1, 13'h0123, 2);
        ctrl_u.wr(3'h1, 13'h1000, 16'hc3a5);
        rd_chk(3'h1, 13'h1000, 8, 6, 8'hff, 16'hc3a5);
        rd_chk(3'h1, 13'h0000, 4, 6, 8'hff, 16'hc3a5);
        apb(1'b1, 12'h000, 32'h2506);
        apb(1'b0, 12'h00c, 32'h0);
        `CHK(rd, 32'h123)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h48)
        rd_chk(3'h2, 13'h1000, 0, 6, 8'h0, 16'h0);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 12'h008, 32'h1);
        ctrl_u.cmd(SCR_CMD_PRE, 3'h0, 13'h0400, 2);
        ctrl_u.cmd(SCR_CMD_MODE, 3'h3, 13'h0004, 12);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h9)
        // Pattern reads: autoclose bit and idle bank must make no difference
        rd_chk(3'h5, 13'h1400, 8, 6, ALT, 16'h0101);
        rd_chk(3'h0, 13'h0000, 4, 6, ALT, 16'h0101);
        rd_chk(3'h0, 13'h0004, 4, 6, ALT >> 4, 16'h0101);
        // Replicate the pattern bit on every line and lengthen the latency
        apb(1'b1, 12'h000, 32'h1525);
        rd_chk(3'h0, 13'h1000, 8, 7, ALT, 16'hffff);
        ctrl_u.wr(3'h1, 13'h1000, 16'h0f0f);
        ctrl_u.cmd(SCR_CMD_ACT, 3'h1, 13'h0007, 2);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd, 32'hc)
        apb(1'b1, 12'h008, 32'hf);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd, 32'h0)
        ctrl_u.cmd(SCR_CMD_MODE, 3'h3, 13'h0003, 12);
        rd_chk(3'h1, 13'h1000, 0, 7, 8'h0, 16'h0);
        ctrl_u.cmd(SCR_CMD_ACT, 3'h1, 13'h0055, 2);
        rd_chk(3'h1, 13'h1000, 8, 7, 8'hff, 16'hc3a5);
        // Fixed chop mode: four beats even with the chop bit high
        ctrl_u.cmd(SCR_CMD_MODE, 3'h0, 13'h0002, 12);
        rd_chk(3'h1, 13'h1004, 4, 7, 8'hff, 16'hc3a5);
        end_sim();
    end
endmodule
`default_nettype wire
